// file: line_arbiter_regs.svh
`ifndef LINE_ARBITER_REGS_SVH
`define LINE_ARBITER_REGS_SVH

// register addresses (8-bit port address)
`define ARB_CONTROL_ADDR     8'h00
`define ARB_COUNT_LOW_ADDR   8'h01
`define ARB_IRQ_STATUS_ADDR  8'h02
`define ARB_IRQ_MASK_ADDR    8'h03

// control register fields
`define ARB_MODE_LOW_BIT     0
`define ARB_MODE_HIGH_BIT    1
`define ARB_LOST_BIT         2
`define ARB_CLK_SEL_BIT      3
`define ARB_FIN_BIT          4
`define ARB_RUN_BIT          5
`define ARB_OVF_BIT          6
`define ARB_MSB_BIT          7

// interrupt status fields
`define ARB_EV_FIN_BIT       0
`define ARB_EV_OVF_BIT       1
`define ARB_EV_LOST_BIT      2
`define ARB_EV_WIDTH         3

// reset values
`define ARB_CONTROL_RESET    8'h00
`define ARB_COUNT_RESET      9'h000
`define ARB_MASK_RESET       3'h0

// arbitration sample points
`define ARB_SAMPLE_BUS_DIV   9'h038
`define ARB_SAMPLE_PRE_DIV   9'h008

// counter tick dividers
`define ARB_BUS_DIV          2'h3
`define ARB_PRE_DIV          2'h1

`endif

// file: line_arbiter_pkg.sv
package line_arbiter_pkg;

  typedef enum logic [1:0] {
    MODE_IDLE    = 2'b00,
    MODE_MEASURE = 2'b01,
    MODE_ARBIT   = 2'b10,
    MODE_RSVD    = 2'b11
  } arb_mode_t;

  // gray along idle -> wait -> count -> done
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_COUNT = 2'b11,
    ST_DONE  = 2'b10
  } arb_state_t;

endpackage

// file: serial_line_arbiter.sv
`include "line_arbiter_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module serial_line_arbiter (
  // clock and reset
  input  wire logic       MCLK_I,
  input  wire logic       RST_I,
  // register port
  input  wire logic [7:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  // serial lines
  input  wire logic       PRESCALER_TICK_I,
  input  wire logic       RXD_I,
  input  wire logic       PORT_TRANSMIT_OUTPUT_I,
  output logic            TXD_O,
  // interrupt
  output logic            IRQ_O
);

  line_arbiter_pkg::arb_mode_t  mode_ff;
  line_arbiter_pkg::arb_state_t state_ff;
  line_arbiter_pkg::arb_state_t nxt_state;

  logic                    clk_sel_ff;
  logic                    lost_ff;
  logic                    fin_ff;
  logic                    ovf_ff;
  logic [8:0]              count_ff;
  logic [1:0]              div_ff;
  logic                    tick;
  logic                    rx_meta_ff;
  logic                    rx_sync_ff;
  logic                    rx_prev_ff;
  logic                    tx_prev_ff;
  logic                    rx_fall;
  logic                    rx_rise;
  logic                    tx_rise;
  logic                    tx_fall;
  logic                    ctl_wr;
  logic                    running;
  logic                    set_fin;
  logic                    set_lost;
  logic                    sample_hit;
  logic [`ARB_EV_WIDTH-1:0] irq_status_ff;
  logic [`ARB_EV_WIDTH-1:0] irq_mask_ff;
  logic [`ARB_EV_WIDTH-1:0] ev;
  logic [8:0]              sample_at;

  assign ctl_wr  = WR_I && (ADDR_I == `ARB_CONTROL_ADDR);

  // receive line synchroniser, first stage read only by second
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
      rx_prev_ff <= 1'b1;
      tx_prev_ff <= 1'b1;
    end else begin
      rx_meta_ff <= RXD_I;
      rx_sync_ff <= rx_meta_ff;
      rx_prev_ff <= rx_sync_ff;
      tx_prev_ff <= PORT_TRANSMIT_OUTPUT_I;
    end
  end

  assign rx_fall = rx_prev_ff && !rx_sync_ff;
  assign rx_rise = !rx_prev_ff && rx_sync_ff;
  assign tx_rise = !tx_prev_ff && PORT_TRANSMIT_OUTPUT_I;
  assign tx_fall = tx_prev_ff && !PORT_TRANSMIT_OUTPUT_I;

  // counter tick divider
  always_ff @(posedge MCLK_I) begin
    if (RST_I || tick) begin
      div_ff <= 2'h0;
    end else if (!clk_sel_ff || PRESCALER_TICK_I) begin
      div_ff <= div_ff + 2'h1;
    end
  end

  always_comb begin
    if (clk_sel_ff) begin
      tick = PRESCALER_TICK_I && (div_ff == `ARB_PRE_DIV);
    end else begin
      tick = (div_ff == `ARB_BUS_DIV);
    end
  end

  // mode, clock select, lost flag
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      mode_ff    <= line_arbiter_pkg::MODE_IDLE;
      clk_sel_ff <= 1'b0;
    end else if (ctl_wr) begin
      mode_ff    <= line_arbiter_pkg::arb_mode_t'(
                    {WDATA_I[`ARB_MODE_HIGH_BIT], WDATA_I[`ARB_MODE_LOW_BIT]});
      clk_sel_ff <= WDATA_I[`ARB_CLK_SEL_BIT];
    end
  end

  assign sample_at  = clk_sel_ff ? `ARB_SAMPLE_PRE_DIV : `ARB_SAMPLE_BUS_DIV;
  assign sample_hit = tick && (state_ff == line_arbiter_pkg::ST_COUNT)
                      && (count_ff == sample_at - 9'h001);
  assign set_lost   = (mode_ff == line_arbiter_pkg::MODE_ARBIT) && sample_hit
                      && !rx_sync_ff;

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      lost_ff <= 1'b0;
    end else if (set_lost) begin
      lost_ff <= 1'b1;
    end else if (ctl_wr && !WDATA_I[`ARB_MODE_HIGH_BIT]) begin
      lost_ff <= 1'b0;
    end
  end

  // sequencing
  always_comb begin
    nxt_state = state_ff;
    set_fin   = 1'b0;
    case (state_ff)
      line_arbiter_pkg::ST_IDLE: begin
        if (mode_ff == line_arbiter_pkg::MODE_MEASURE ||
            mode_ff == line_arbiter_pkg::MODE_ARBIT) begin
          nxt_state = line_arbiter_pkg::ST_WAIT;
        end
      end
      line_arbiter_pkg::ST_WAIT: begin
        if (mode_ff == line_arbiter_pkg::MODE_MEASURE) begin
          if (!clk_sel_ff && rx_fall) begin
            nxt_state = line_arbiter_pkg::ST_COUNT;
          end else if (clk_sel_ff && !rx_sync_ff) begin
            nxt_state = line_arbiter_pkg::ST_COUNT;
          end
        end else if (tx_rise) begin
          nxt_state = line_arbiter_pkg::ST_COUNT;
        end
      end
      line_arbiter_pkg::ST_COUNT: begin
        if (mode_ff == line_arbiter_pkg::MODE_MEASURE) begin
          if ((!clk_sel_ff && rx_fall) || (clk_sel_ff && rx_rise)) begin
            nxt_state = line_arbiter_pkg::ST_DONE;
            set_fin   = 1'b1;
          end
        end else if (tx_fall) begin
          nxt_state = line_arbiter_pkg::ST_WAIT;
        end else if (set_lost || (sample_hit && rx_sync_ff)) begin
          nxt_state = line_arbiter_pkg::ST_DONE;
        end
      end
      line_arbiter_pkg::ST_DONE: begin
        if (mode_ff == line_arbiter_pkg::MODE_ARBIT && tx_rise) begin
          nxt_state = line_arbiter_pkg::ST_COUNT;
        end
      end
      default: nxt_state = line_arbiter_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I || ctl_wr || mode_ff == line_arbiter_pkg::MODE_IDLE ||
        mode_ff == line_arbiter_pkg::MODE_RSVD) begin
      state_ff <= line_arbiter_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign running = (state_ff == line_arbiter_pkg::ST_COUNT);

  // counter and overflow
  always_ff @(posedge MCLK_I) begin
    if (RST_I || ctl_wr || mode_ff == line_arbiter_pkg::MODE_IDLE) begin
      count_ff <= `ARB_COUNT_RESET;
      ovf_ff   <= 1'b0;
    end else if ((state_ff != line_arbiter_pkg::ST_COUNT &&
                  nxt_state == line_arbiter_pkg::ST_COUNT && tx_rise) ||
                 (state_ff == line_arbiter_pkg::ST_COUNT &&
                  nxt_state == line_arbiter_pkg::ST_WAIT)) begin
      count_ff <= `ARB_COUNT_RESET;
    end else if (running && tick) begin
      count_ff <= count_ff + 9'h001;
      if (count_ff == 9'h1FF) begin
        ovf_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I || ctl_wr) begin
      fin_ff <= 1'b0;
    end else if (set_fin) begin
      fin_ff <= 1'b1;
    end
  end

  // pin override
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      TXD_O <= 1'b1;
    end else begin
      TXD_O <= PORT_TRANSMIT_OUTPUT_I || lost_ff || set_lost;
    end
  end

  // interrupts: set wins over write-one-to-clear
  assign ev[`ARB_EV_FIN_BIT]  = set_fin;
  assign ev[`ARB_EV_OVF_BIT]  = running && tick && (count_ff == 9'h1FF);
  assign ev[`ARB_EV_LOST_BIT] = set_lost;

  generate
    for (genvar i = 0; i < `ARB_EV_WIDTH; i++) begin : g_irq
      always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
          irq_status_ff[i] <= 1'b0;
        end else if (ev[i]) begin
          irq_status_ff[i] <= 1'b1;
        end else if (WR_I && ADDR_I == `ARB_IRQ_STATUS_ADDR && WDATA_I[i]) begin
          irq_status_ff[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      irq_mask_ff <= `ARB_MASK_RESET;
    end else if (WR_I && ADDR_I == `ARB_IRQ_MASK_ADDR) begin
      irq_mask_ff <= WDATA_I[`ARB_EV_WIDTH-1:0];
    end
  end

  assign IRQ_O = |(irq_status_ff & irq_mask_ff);

  // read data, one cycle after strobe
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      RDATA_O <= 8'h00;
    end else if (RD_I) begin
      case (ADDR_I)
        `ARB_CONTROL_ADDR: begin
          RDATA_O <= {count_ff[8], ovf_ff, running, fin_ff,
                      clk_sel_ff, lost_ff, mode_ff};
        end
        `ARB_COUNT_LOW_ADDR:  RDATA_O <= count_ff[7:0];
        `ARB_IRQ_STATUS_ADDR: RDATA_O <= {5'h00, irq_status_ff};
        `ARB_IRQ_MASK_ADDR:   RDATA_O <= {5'h00, irq_mask_ff};
        default:              RDATA_O <= 8'h00;
      endcase
    end else begin
      RDATA_O <= 8'h00;
    end
  end

  property p_write_clears;
    @(posedge MCLK_I) disable iff (RST_I) ctl_wr |=> (count_ff == 9'h000) && !fin_ff;
  endproperty
  a_write_clears: assert property (p_write_clears) else $error("control write did not clear");

  property p_idle_hold;
    @(posedge MCLK_I) disable iff (RST_I)
      (mode_ff == line_arbiter_pkg::MODE_IDLE) |=> (count_ff == 9'h000) || ctl_wr;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle counter not held");

  property p_lost_tx;
    @(posedge MCLK_I) disable iff (RST_I) lost_ff |=> TXD_O;
  endproperty
  a_lost_tx: assert property (p_lost_tx) else $error("transmit not forced high");

  property p_lost_set;
    @(posedge MCLK_I) disable iff (RST_I) set_lost |=> lost_ff;
  endproperty
  a_lost_set: assert property (p_lost_set) else $error("lost flag not set");

  property p_lost_clear;
    @(posedge MCLK_I) disable iff (RST_I)
      (ctl_wr && !WDATA_I[`ARB_MODE_HIGH_BIT] && !set_lost) |=> !lost_ff;
  endproperty
  a_lost_clear: assert property (p_lost_clear) else $error("lost flag not cleared");

  property p_ovf_sticky;
    @(posedge MCLK_I) disable iff (RST_I) (ovf_ff && !ctl_wr) |=> ovf_ff;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow not sticky");

  property p_count_stopped;
    @(posedge MCLK_I) disable iff (RST_I)
      (!running && !ctl_wr && mode_ff != line_arbiter_pkg::MODE_IDLE && !tx_rise
       && !tx_fall) |=> $stable(count_ff);
  endproperty
  a_count_stopped: assert property (p_count_stopped) else $error("counter moved while stopped");

  property p_fin_set;
    @(posedge MCLK_I) disable iff (RST_I) (set_fin && !ctl_wr) |=> fin_ff && !running;
  endproperty
  a_fin_set: assert property (p_fin_set) else $error("finish flag not set");

endmodule // serial_line_arbiter

`default_nettype wire

// file: bus_node_model.sv
`timescale 1ns/1ps
`default_nettype none
// shared line: pulled up, any node may pull it low (wired and)
module bus_node_model (
  input  wire logic txd_i,
  input  wire logic other_low_i,
  output logic      rxd_o
);
  assign rxd_o = txd_i & ~other_low_i;
endmodule // bus_node_model
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       tick = 1'b0;
  logic [2:0] tcnt = 3'h0;
  logic       rxd;
  logic       ptx = 1'b1;
  logic       txd;
  logic       irq;
  logic       low = 1'b0;
  logic [7:0] v;
  int         failures = 0;
  int         total_checks = 0;

  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    tcnt <= tcnt + 3'h1;
    tick <= (tcnt == 3'h7);
  end

  serial_line_arbiter i_dut (
    .MCLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .PRESCALER_TICK_I(tick), .RXD_I(rxd),
    .PORT_TRANSMIT_OUTPUT_I(ptx), .TXD_O(txd), .IRQ_O(irq)
  );
  bus_node_model i_node (.txd_i(txd), .other_low_i(low), .rxd_o(rxd));

  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_rng(input string n, input logic [7:0] lo, input logic [7:0] hi,
                         input logic [7:0] g);
    total_checks++;
    if (!(g >= lo && g <= hi) || $isunknown(g)) begin
      failures++;
      $display("BAD %s expected %h..%h seen %h", n, lo, hi, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    cyc(20000);
    failures++;
    tally_and_finish;
  end

  initial begin
    cyc(12);
    rst <= 1'b0;
    rdr(8'h00, v); chk("ctl rst", 8'h00, v);
    rdr(8'h01, v); chk("cnt rst", 8'h00, v);
    wrr(8'h05, 8'hff);
    rdr(8'h05, v); chk("unmapped", 8'h00, v);
    $display("test reset done");
    // break length, line already low when enabled
    low <= 1'b1;
    cyc(4);
    wrr(8'h00, 8'h09);
    cyc(80);
    rdr(8'h00, v); chk("ctl running", 8'h29, v);
    cyc(80);
    low <= 1'b0;
    cyc(40);
    rdr(8'h00, v); chk("ctl done1", 8'h19, v);
    rdr(8'h01, v); chk_rng("cnt1", 8'h08, 8'h0b, v);
    $display("test break done");
    // baud: falling edge to falling edge, 200 cycles apart
    wrr(8'h00, 8'h01);
    low <= 1'b1;
    cyc(10);
    low <= 1'b0;
    cyc(190);
    low <= 1'b1;
    cyc(10);
    low <= 1'b0;
    cyc(20);
    rdr(8'h00, v); chk("ctl done0", 8'h11, v);
    rdr(8'h01, v); chk_rng("cnt0", 8'h30, 8'h33, v);
    rdr(8'h02, v); chk("irq stat", 8'h01, v & 8'h01);
    chk("irq masked", 8'h00, {7'h0, irq});
    wrr(8'h03, 8'h01);
    cyc(1);
    chk("irq on", 8'h01, {7'h0, irq});
    wrr(8'h02, 8'h01);
    cyc(1);
    chk("irq clr", 8'h00, {7'h0, irq});
    wrr(8'h00, 8'h01);
    rdr(8'h00, v); chk("ctl clr", 8'h01, v);
    rdr(8'h01, v); chk("cnt clr", 8'h00, v);
    $display("test baud done");
    // overflow after 512 counts
    low <= 1'b1;
    cyc(10);
    low <= 1'b0;
    cyc(2100);
    rdr(8'h00, v); chk("ovf", 8'h40, v & 8'h40);
    rdr(8'h02, v); chk("ovf ev", 8'h02, v & 8'h02);
    wrr(8'h00, 8'h00);
    low <= 1'b1;
    cyc(40);
    low <= 1'b0;
    cyc(40);
    rdr(8'h00, v); chk("idle ctl", 8'h00, v);
    rdr(8'h01, v); chk("idle cnt", 8'h00, v);
    wrr(8'h00, 8'h03);
    cyc(20);
    rdr(8'h00, v); chk("rsvd ctl", 8'h03, v);
    wrr(8'h00, 8'h00);
    $display("test overflow done");
    // arbitration lost: other node dominant at sample point
    ptx <= 1'b0;
    wrr(8'h00, 8'h02);
    cyc(4);
    ptx <= 1'b1;
    low <= 1'b1;
    cyc(260);
    rdr(8'h00, v); chk("lost", 8'h06, v & 8'h07);
    ptx <= 1'b0;
    cyc(4);
    chk("txd forced", 8'h01, {7'h0, txd});
    rdr(8'h02, v); chk("lost ev", 8'h04, v & 8'h04);
    low <= 1'b0;
    wrr(8'h00, 8'h00);
    rdr(8'h00, v); chk("lost clr", 8'h00, v & 8'h07);
    // arbitration won, prescaler clock
    wrr(8'h00, 8'h0a);
    cyc(4);
    ptx <= 1'b1;
    cyc(200);
    rdr(8'h00, v); chk("won", 8'h0a, v & 8'h0f);
    ptx <= 1'b0;
    cyc(4);
    chk("txd follows", 8'h00, {7'h0, txd});
    // transmit drops before the sample point
    wrr(8'h00, 8'h02);
    cyc(4);
    ptx <= 1'b1;
    cyc(40);
    ptx <= 1'b0;
    cyc(8);
    rdr(8'h01, v); chk("early cnt", 8'h00, v);
    rdr(8'h00, v); chk("early stop", 8'h02, v & 8'h27);
    ptx <= 1'b1;
    cyc(40);
    rdr(8'h00, v); chk("rearmed", 8'h22, v & 8'h27);
    $display("test arbitration done");
    tally_and_finish;
  end
endmodule // tb_top
`default_nettype wire
